// [shared/iap_pkg.sv]
// constants, types and register map of the in-application programming sequencer
package iap_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_AUX = 6'h00;
  localparam logic [5:0] IDX_CTRL = 6'h01;
  localparam logic [5:0] IDX_ALO = 6'h02;
  localparam logic [5:0] IDX_AHI = 6'h03;
  localparam logic [5:0] IDX_DLO = 6'h04;
  localparam logic [5:0] IDX_DHI = 6'h05;
  // control and aux register field positions
  localparam int CTL_RD_TRIG = 0;
  localparam int CTL_RD_EN = 1;
  localparam int CTL_PROG_TRIG = 2;
  localparam int CTL_EW_EN = 3;
  localparam int CTL_MODE_LSB = 4;
  localparam int AUX_BUF_CLR = 0;
  // op_mode_select_field codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // reset values
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  // unlock key, arbitrary value
  localparam logic [15:0] UNLOCK_KEY = 16'h5aa5;
  // geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int PAGE_WORDS = 64;
  localparam int WIDX_W = 6;
  localparam logic [5:0] LAST_IDX = 6'h3f;
  // timing: unlock window
  localparam int CLK_KHZ = 10000;
  localparam int UNLOCK_WIN_US = 100;
  localparam int UNLOCK_WIN_CYC = (UNLOCK_WIN_US * CLK_KHZ) / 1000;
  localparam int WIN_W = 11;
  // flash array operations
  localparam logic [1:0] FOP_READ = 2'h0;
  localparam logic [1:0] FOP_ERASE = 2'h1;
  localparam logic [1:0] FOP_WRITE = 2'h2;

  typedef struct packed {
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } iap_fl_cmd_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_KEY = 7'b0000010,
    ST_ERASE = 7'b0000100,
    ST_SCAN = 7'b0001000,
    ST_FETCH = 7'b0010000,
    ST_PROG = 7'b0100000,
    ST_READ = 7'b1000000
  } iap_state_t;
endpackage

// [hdl/iap_wbuf_mem.sv]
// one-page write buffer memory with registered read data
`timescale 1ns/1ps
module iap_wbuf_mem import iap_pkg::*; (
  // clock
  input wire logic ref_clk,
  // write port
  input wire logic wr_en,
  input wire logic [WIDX_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // read port
  input wire logic [WIDX_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data_ff
);
  logic [DATA_W-1:0] mem [PAGE_WORDS];

  // no reset: contents only count where the valid flag is set
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule

// [hdl/iap_flash_seq.sv]
// in-application programming sequencer: apb registers, write buffer, flash array sequencing
// Functional notes
// - mode 001 plus trigger erases addressed page
// - mode 000 selects word write
// - write trigger commits buffered word, self-clears
// - program trigger high stalls the cpu
// - erase always clears a whole page
// - buffer commits as one page, no overflow
// - rewrite same page after buffer clear allowed
// - read needs mode 011 and read enable
// - read trigger fetches word, then self-clears
// - reads work without unlock
// - read trigger high stalls the cpu
// - successful unlock sets enabled flag
// - buffer holds 64 words of one page
// - buffer clear bit clears buffer, self-clears
`timescale 1ns/1ps
module iap_flash_seq import iap_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash array
  output logic fl_req,
  output iap_fl_cmd_t fl_cmd,
  input wire logic fl_ack,
  input wire logic [DATA_W-1:0] fl_rdata,
  // cpu
  output logic cpu_stall
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  iap_state_t state_ff, nxt_state;
  logic [7:0] aux_ff, nxt_aux;
  logic [2:0] mode_ff, nxt_mode;
  logic ew_en_ff, nxt_ew_en;
  logic prog_trig_ff, nxt_prog_trig;
  logic rd_en_ff, nxt_rd_en;
  logic rd_trig_ff, nxt_rd_trig;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [7:0] dlo_ff, nxt_dlo;
  logic [7:0] dhi_ff, nxt_dhi;
  logic [PAGE_WORDS-1:0] valid_ff, nxt_valid;
  logic [WIDX_W-1:0] idx_ff, nxt_idx;
  logic [WIN_W-1:0] win_ff, nxt_win;
  logic key_ok_ff, nxt_key_ok;
  logic req_ff, nxt_req;
  iap_fl_cmd_t cmd_ff, nxt_cmd;
  logic [31:0] prdata_ff, nxt_prdata;
  logic err_ff, nxt_err;

  logic setup;
  logic wr_acc;
  logic mapped;
  logic [5:0] ridx;
  logic buf_we;
  logic [DATA_W-1:0] buf_rdata;
  logic [8:0] page;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign ridx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0) && (ridx <= IDX_DHI);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign page = addr_ff[ADDR_W-1:WIDX_W];
  // zero wait states: every access answers in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = err_ff && psel && penable;
  assign fl_req = req_ff;
  assign fl_cmd = cmd_ff;
  assign cpu_stall = prog_trig_ff || rd_trig_ff;

  // buffer loads only in write mode and only on the high byte, pairing with the held low byte
  assign buf_we = wr_acc && (ridx == IDX_DHI) && (mode_ff == MODE_WRITE) && (state_ff == ST_IDLE);

  iap_wbuf_mem u_wbuf (
    .ref_clk(ref_clk),
    .wr_en(buf_we),
    .wr_addr(addr_ff[WIDX_W-1:0]),
    .wr_data({pwdata[7:0], dlo_ff}),
    .rd_addr(idx_ff),
    .rd_data_ff(buf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_aux = aux_ff;
    nxt_mode = mode_ff;
    nxt_ew_en = ew_en_ff;
    nxt_prog_trig = prog_trig_ff;
    nxt_rd_en = rd_en_ff;
    nxt_rd_trig = rd_trig_ff;
    nxt_addr = addr_ff;
    nxt_dlo = dlo_ff;
    nxt_dhi = dhi_ff;
    nxt_valid = valid_ff;
    nxt_idx = idx_ff;
    nxt_win = win_ff;
    nxt_key_ok = key_ok_ff;
    nxt_req = req_ff;
    nxt_cmd = cmd_ff;
    nxt_prdata = prdata_ff;
    nxt_err = err_ff;

    // read data and error are captured in the setup cycle so prdata comes from a flop
    if (setup) begin
      nxt_err = !mapped;
      nxt_prdata = 32'h0;
      if (mapped) begin
        unique case (ridx)
          IDX_AUX: nxt_prdata[7:0] = aux_ff;
          IDX_CTRL: begin
            nxt_prdata[CTL_RD_TRIG] = rd_trig_ff;
            nxt_prdata[CTL_RD_EN] = rd_en_ff;
            nxt_prdata[CTL_PROG_TRIG] = prog_trig_ff;
            nxt_prdata[CTL_EW_EN] = ew_en_ff;
            nxt_prdata[CTL_MODE_LSB +: 3] = mode_ff;
          end
          IDX_ALO: nxt_prdata[7:0] = addr_ff[7:0];
          IDX_AHI: nxt_prdata[6:0] = addr_ff[ADDR_W-1:8];
          IDX_DLO: nxt_prdata[7:0] = dlo_ff;
          IDX_DHI: nxt_prdata[7:0] = dhi_ff;
          default: nxt_prdata = 32'h0;
        endcase
      end
    end

    // software writes
    if (wr_acc) begin
      unique case (ridx)
        IDX_AUX: nxt_aux = pwdata[7:0];
        IDX_CTRL: begin
          nxt_mode = pwdata[CTL_MODE_LSB +: 3];
          nxt_rd_en = pwdata[CTL_RD_EN];
          // triggers are set only by writing one; software can only clear the enable
          if (pwdata[CTL_PROG_TRIG]) begin
            nxt_prog_trig = 1'b1;
          end
          if (pwdata[CTL_RD_TRIG]) begin
            nxt_rd_trig = 1'b1;
          end
          if (!pwdata[CTL_EW_EN]) begin
            nxt_ew_en = 1'b0;
          end
        end
        IDX_ALO: nxt_addr[7:0] = pwdata[7:0];
        IDX_AHI: nxt_addr[ADDR_W-1:8] = pwdata[6:0];
        IDX_DLO: nxt_dlo = pwdata[7:0];
        IDX_DHI: begin
          nxt_dhi = pwdata[7:0];
          if (buf_we) begin
            nxt_valid[addr_ff[WIDX_W-1:0]] = 1'b1;
          end
        end
        default: nxt_aux = aux_ff;
      endcase
    end

    // sequencer; placed after bus writes so hardware sets win
    unique case (state_ff)
      ST_IDLE: begin
        if (prog_trig_ff) begin
          if (mode_ff == MODE_UNLOCK) begin
            nxt_win = '0;
            nxt_key_ok = 1'b0;
            nxt_state = ST_KEY;
          end else if (mode_ff == MODE_ERASE && ew_en_ff) begin
            nxt_req = 1'b1;
            nxt_cmd.op = FOP_ERASE;
            nxt_cmd.addr = {page, 6'h00};
            nxt_cmd.wdata = '0;
            nxt_state = ST_ERASE;
          end else if (mode_ff == MODE_WRITE && ew_en_ff) begin
            nxt_idx = '0;
            nxt_state = ST_SCAN;
          end else begin
            nxt_prog_trig = 1'b0;
          end
        end else if (rd_trig_ff) begin
          // reads do not look at the erase/write enable
          if (mode_ff == MODE_READ && rd_en_ff) begin
            nxt_req = 1'b1;
            nxt_cmd.op = FOP_READ;
            nxt_cmd.addr = addr_ff;
            nxt_cmd.wdata = '0;
            nxt_state = ST_READ;
          end else begin
            nxt_rd_trig = 1'b0;
          end
        end else if (aux_ff[AUX_BUF_CLR]) begin
          // old words are dropped, the page itself is untouched so it may be written again
          nxt_valid = '0;
          // a fresh software request in the same cycle stays pending: set wins
          nxt_aux[AUX_BUF_CLR] = wr_acc && (ridx == IDX_AUX) && pwdata[AUX_BUF_CLR];
        end
      end
      ST_KEY: begin
        nxt_win = win_ff + 1'b1;
        if (wr_acc && ridx == IDX_DHI && {pwdata[7:0], dlo_ff} == UNLOCK_KEY) begin
          nxt_key_ok = 1'b1;
        end
        // window always runs to its end, whatever was written
        if (win_ff == WIN_W'(UNLOCK_WIN_CYC - 1)) begin
          nxt_prog_trig = 1'b0;
          if (nxt_key_ok) begin
            nxt_ew_en = 1'b1;
          end
          nxt_state = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (fl_ack) begin
          nxt_req = 1'b0;
          nxt_prog_trig = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      ST_SCAN: begin
        if (valid_ff[idx_ff]) begin
          nxt_state = ST_FETCH;
        end else if (idx_ff == LAST_IDX) begin
          nxt_prog_trig = 1'b0;
          nxt_valid = '0;
          nxt_state = ST_IDLE;
        end else begin
          nxt_idx = idx_ff + 1'b1;
        end
      end
      ST_FETCH: begin
        nxt_req = 1'b1;
        nxt_cmd.op = FOP_WRITE;
        nxt_cmd.addr = {page, idx_ff};
        nxt_cmd.wdata = buf_rdata;
        nxt_state = ST_PROG;
      end
      ST_PROG: begin
        if (fl_ack) begin
          nxt_req = 1'b0;
          if (idx_ff == LAST_IDX) begin
            // committed words leave the buffer so the next single word stands alone
            nxt_prog_trig = 1'b0;
            nxt_valid = '0;
            nxt_state = ST_IDLE;
          end else begin
            nxt_idx = idx_ff + 1'b1;
            nxt_state = ST_SCAN;
          end
        end
      end
      ST_READ: begin
        if (fl_ack) begin
          nxt_req = 1'b0;
          nxt_dlo = fl_rdata[7:0];
          nxt_dhi = fl_rdata[15:8];
          nxt_rd_trig = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      aux_ff <= AUX_RST;
      mode_ff <= MODE_RST;
      ew_en_ff <= 1'b0;
      prog_trig_ff <= 1'b0;
      rd_en_ff <= 1'b0;
      rd_trig_ff <= 1'b0;
      addr_ff <= '0;
      dlo_ff <= 8'h00;
      dhi_ff <= 8'h00;
      valid_ff <= '0;
      idx_ff <= '0;
      win_ff <= '0;
      key_ok_ff <= 1'b0;
      req_ff <= 1'b0;
      cmd_ff <= '0;
      prdata_ff <= 32'h0;
      err_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      aux_ff <= nxt_aux;
      mode_ff <= nxt_mode;
      ew_en_ff <= nxt_ew_en;
      prog_trig_ff <= nxt_prog_trig;
      rd_en_ff <= nxt_rd_en;
      rd_trig_ff <= nxt_rd_trig;
      addr_ff <= nxt_addr;
      dlo_ff <= nxt_dlo;
      dhi_ff <= nxt_dhi;
      valid_ff <= nxt_valid;
      idx_ff <= nxt_idx;
      win_ff <= nxt_win;
      key_ok_ff <= nxt_key_ok;
      req_ff <= nxt_req;
      cmd_ff <= nxt_cmd;
      prdata_ff <= nxt_prdata;
      err_ff <= nxt_err;
    end
  end
endmodule

// [tb/iap_flash_checker.sv]
// port assertions for the programming sequencer
`timescale 1ns/1ps
module iap_flash_checker import iap_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  // flash array and cpu
  input wire logic fl_req,
  input iap_fl_cmd_t fl_cmd,
  input wire logic fl_ack,
  input wire logic cpu_stall
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // a ctrl write that asks for a read while idle
  sequence s_rd_trig;
    psel && penable && pwrite && paddr == {IDX_CTRL, 2'b00} && pwdata[6:4] == MODE_READ &&
      pwdata[1:0] == 2'b11 && !cpu_stall;
  endsequence
  sequence s_rd_req;
    ##[1:3] fl_req && fl_cmd.op == FOP_READ;
  endsequence
  property p_hold;
    fl_req && !fl_ack |=> fl_req && $stable(fl_cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("flash request dropped early");
  property p_drop;
    fl_ack |=> !fl_req;
  endproperty
  a_drop: assert property (p_drop) else $error("request held after ack");
  property p_stall;
    fl_req |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu runs during flash op");
  property p_page;
    fl_req && fl_cmd.op == FOP_ERASE |-> fl_cmd.addr[5:0] == 6'h00;
  endproperty
  a_page: assert property (p_page) else $error("erase not page aligned");
  property p_rd_start;
    s_rd_trig |-> s_rd_req;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read not started");
  property p_rd_done;
    fl_ack && fl_cmd.op == FOP_READ |=> !cpu_stall;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read trigger stuck");
  property p_er_done;
    fl_ack && fl_cmd.op == FOP_ERASE |=> !cpu_stall;
  endproperty
  a_er_done: assert property (p_er_done) else $error("erase trigger stuck");
  property p_stall_src;
    $rose(cpu_stall) |-> $past(psel && penable && pwrite && paddr == {IDX_CTRL, 2'b00});
  endproperty
  a_stall_src: assert property (p_stall_src) else $error("stall without trigger");
endmodule

bind iap_flash_seq iap_flash_checker chk_u (.ref_clk(ref_clk), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .fl_req(fl_req),
  .fl_cmd(fl_cmd), .fl_ack(fl_ack), .cpu_stall(cpu_stall));

// [tb/iap_flash_model.sv]
// behavioural flash array answering the sequencer
`timescale 1ns/1ps
module iap_flash_model import iap_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request side
  input wire logic fl_req,
  input iap_fl_cmd_t fl_cmd,
  output logic fl_ack,
  output logic [DATA_W-1:0] fl_rdata
);
  logic [15:0] mem [0:32767];
  int cnt;
  int lat;
  initial begin
    for (int a = 0; a < 32768; a++) mem[a] = a[15:0] ^ 16'h3c3c;
    fl_rdata = 16'h0000;
    cnt = 0;
    lat = 1;
  end
  // latency alternates short and long; data toggles outside ack
  always @(posedge ref_clk) begin
    fl_ack <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (rst) begin
      cnt <= 0;
    end else if (fl_req && fl_ack !== 1'b1) begin
      if (cnt == lat) begin
        fl_ack <= 1'b1;
        cnt <= 0;
        lat <= 5 - lat;
        case (fl_cmd.op)
          FOP_READ: fl_rdata <= mem[fl_cmd.addr];
          FOP_ERASE: for (int k = 0; k < 64; k++) mem[{fl_cmd.addr[14:6], k[5:0]}] <= 16'h0000;
          default: mem[fl_cmd.addr] <= fl_cmd.wdata;
        endcase
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// [tb/tb_iap_flash_write_read_sequencer.sv]
// self-checking bench for the programming sequencer
`timescale 1ns/1ps
module tb_iap_flash_write_read_sequencer import iap_pkg::*; ;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, fl_req, fl_ack, cpu_stall, e;
  iap_fl_cmd_t fl_cmd;
  logic [DATA_W-1:0] fl_rdata;
  int n_mismatch = 0, check_count = 0, seed = 32'h38fef0a2;
  logic [15:0] mdl [int];
  logic [14:0] a1, a2;
  logic [15:0] d1, d2;
  always #50 ref_clk = ~ref_clk;
  iap_flash_seq dut_u (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_ack(fl_ack), .fl_rdata(fl_rdata), .cpu_stall(cpu_stall));
  iap_flash_model fl_u (.ref_clk(ref_clk), .rst(rst), .fl_req(fl_req), .fl_cmd(fl_cmd),
    .fl_ack(fl_ack), .fl_rdata(fl_rdata));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // waits for pready however long it takes; only the watchdog ends a stuck access
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // triggers self-clear; poll instead of assuming a duration
  task automatic idle;
    int n;
    n = 0;
    do begin apb(0, IDX_CTRL, 0); n++; end while ((r[2] | r[0]) !== 1'b0 && n < 1000);
    if (n >= 1000) chk(1, 0);
  endtask
  task automatic seta(input logic [14:0] a);
    apb(1, IDX_ALO, a[7:0]);
    apb(1, IDX_AHI, {1'b0, a[14:8]});
  endtask
  function automatic logic [15:0] ex(int a);
    return mdl.exists(a) ? mdl[a] : a[15:0] ^ 16'h3c3c;
  endfunction
  task automatic rdw(input logic [14:0] a);
    logic [15:0] w;
    seta(a);
    apb(1, IDX_CTRL, 8'h3b);
    idle;
    apb(0, IDX_DLO, 0);
    w[7:0] = r[7:0];
    apb(0, IDX_DHI, 0);
    w[15:8] = r[7:0];
    chk(32'(w), 32'(ex(int'(a))));
  endtask
  // bit3 kept high in ctrl writes: a zero there relocks
  task automatic ldw(input logic [14:0] a, input logic [15:0] d, input logic go);
    apb(1, IDX_CTRL, 8'h08);
    seta(a);
    apb(1, IDX_DLO, d[7:0]);
    apb(1, IDX_DHI, d[15:8]);
    if (go) begin apb(1, IDX_CTRL, 8'h0c); idle; end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    apb(0, IDX_CTRL, 0); chk(r, {25'h0, MODE_RST, 4'h0});
    apb(0, IDX_AUX, 0); chk(r, {24'h0, AUX_RST});
    apb(0, 6'h3f, 0); chk({31'h0, e}, 1);
    a1 = 15'($random(seed)); d1 = 16'($random(seed)); d2 = 16'($random(seed));
    a2 = {a1[14:6], a1[5:0] ^ 6'h15};
    rdw(a1);
    apb(1, IDX_CTRL, 8'h1c); idle; rdw(a1);
    apb(1, IDX_CTRL, 8'h6c); apb(1, IDX_DLO, UNLOCK_KEY[7:0]); apb(1, IDX_DHI, UNLOCK_KEY[15:8]); idle;
    chk({31'h0, r[3]}, 1);
    seta(a1); apb(1, IDX_CTRL, 8'h1c); idle;
    for (int k = 0; k < 64; k++) mdl[int'({a1[14:6], k[5:0]})] = 16'h0000;
    rdw({a1[14:6], 6'h00}); rdw({a1[14:6], 6'h3f});
    ldw(a1, d1, 1); mdl[int'(a1)] = d1;
    ldw(a2, d2, 1); mdl[int'(a2)] = d2;
    rdw(a1); rdw(a2); rdw({a1[14:6], a1[5:0] ^ 6'h2a});
    ldw(a1, ~d1, 0); apb(1, IDX_AUX, 8'h01);
    do apb(0, IDX_AUX, 0); while (r[0] !== 1'b0 && check_count < 5000);
    chk({31'h0, r[0]}, 0);
    apb(1, IDX_CTRL, 8'h0c); idle; rdw(a1);
    ldw(a1, d2, 1); mdl[int'(a1)] = d2; rdw(a1);
    apb(1, IDX_CTRL, 8'h00); apb(0, IDX_CTRL, 0); chk({31'h0, r[3]}, 0);
    seta(a1); apb(1, IDX_CTRL, 8'h14); idle; rdw(a1);
    for (int k = 0; k < 4; k++) rdw(15'($random(seed)));
    end_of_test;
  end
  initial begin
    #(100 * 60000);
    n_mismatch++;
    end_of_test;
  end
endmodule
